//--- mscd_pkg.sv
// Package with constants and types for the motion slave command decoder
// Functional notes
// - Each command opcode is one byte from one host command register write.
// - Bits 5:4 equal 11 means system command; bits 3:0 select it; 7:6 ignored.
// - Bits 5:4 of 00, 01, 10 mean slave start, output, input; 3:0 address.
// - Eleven system command opcodes are recognised; others flagged as unknown.
// - Slave result data starts with the slave address byte.
// - Results pair with commands by slave address, not issue order.
// - At most sixteen slaves, each with a distinct address.
// - Slave serial link runs at most 125 kbit/s.
// - Host data path is eight bits wide.
// - Buffer two commands; third command's first byte sets full flag, refuses bytes.
// - Raise interrupt on results; halt accepting commands while output unread.
package mscd_pkg;

  localparam int unsigned BYTE_W      = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned NUM_SLAVES  = 16;
  localparam int unsigned CMD_DEPTH   = 2;
  localparam int unsigned CLK_HZ      = 200_000_000;
  localparam int unsigned LINK_BPS    = 125_000;
  // Longest rate: round the divider up so the rate never exceeds the limit
  localparam int unsigned BIT_CYCLES  = (CLK_HZ + LINK_BPS - 1) / LINK_BPS;
  localparam int unsigned CLASS_HI    = 5;
  localparam int unsigned CLASS_LO    = 4;

  // Command classes from opcode bits 5:4
  typedef enum logic [1:0] {
    MSCD_SLV_START  = 2'h0,
    MSCD_SLV_OUTPUT = 2'h1,
    MSCD_SLV_INPUT  = 2'h2,
    MSCD_SYSTEM     = 2'h3
  } mscd_class_t;

  // System command selectors in bits 3:0
  localparam logic [3:0] SYS_INIT_POLL  = 4'h0;
  localparam logic [3:0] SYS_POLL_START = 4'h1;
  localparam logic [3:0] SYS_POLL_STOP  = 4'h2;
  localparam logic [3:0] SYS_EMERG_STOP = 4'h3;
  localparam logic [3:0] SYS_BUSY_LIST  = 4'h4;
  localparam logic [3:0] SYS_DIRECT     = 4'h5;
  localparam logic [3:0] SYS_INTERLOCK  = 4'h6;
  localparam logic [3:0] SYS_ERR_COUNT  = 4'h7;
  localparam logic [3:0] SYS_POLL_PROH  = 4'h8;
  localparam logic [3:0] SYS_POLL_RES   = 4'h9;
  localparam logic [3:0] SYS_STAT_CHECK = 4'hF;

  // Decoded command handed to the execution side
  typedef struct packed {
    mscd_class_t cls;
    logic [3:0]  code;   // System selector or slave address
    logic        known;  // Valid system code, always one for slave commands
  } mscd_cmd_t;

  // Result coming back from a slave channel
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } mscd_res_t;

endpackage : mscd_pkg

//--- mscd_opdec.sv
// Opcode decoder for the motion slave command decoder
`timescale 1ns/10ps
`default_nettype none
module mscd_opdec (
  input  wire logic [7:0]          opcode_i, // Command byte
  output mscd_pkg::mscd_cmd_t      cmd_o     // Decoded command
);
  import mscd_pkg::*;

  // Classify by bits 5:4, ignore bits 7:6
  always_comb begin
    cmd_o.cls  = mscd_class_t'(opcode_i[CLASS_HI:CLASS_LO]);
    cmd_o.code = opcode_i[3:0];
    cmd_o.known = 1'b1;
    if (cmd_o.cls == MSCD_SYSTEM) begin
      unique case (opcode_i[3:0])
        SYS_INIT_POLL, SYS_POLL_START, SYS_POLL_STOP, SYS_EMERG_STOP,
        SYS_BUSY_LIST, SYS_DIRECT, SYS_INTERLOCK, SYS_ERR_COUNT,
        SYS_POLL_PROH, SYS_POLL_RES, SYS_STAT_CHECK: cmd_o.known = 1'b1;
        default: cmd_o.known = 1'b0;
      endcase
    end
  end
endmodule // mscd_opdec
`default_nettype wire

//--- mscd_top.sv
// Command buffer, decode, result return and link rate tick of the decoder
`timescale 1ns/10ps
`default_nettype none
module mscd_top (
  input  wire logic                 clock_i,      // 200 MHz clock
  input  wire logic                 resetn_i,     // Async reset, active low
  input  wire logic                 cmd_wr_i,     // Host write to command register
  input  wire logic                 data_wr_i,    // Host write to data register
  input  wire logic [7:0]           wdata_i,      // Host write byte
  input  wire logic                 rd_i,         // Host read of data register
  output logic                      input_buffer_full_flag_o, // Full flag
  output logic [7:0]                rdata_o,      // Result byte to host
  output logic                      obf_o,        // Result byte waiting
  output logic                      irq_o,        // Result interrupt, level
  output logic                      cmd_valid_o,  // Head command available
  output mscd_pkg::mscd_cmd_t       cmd_o,        // Head command
  output logic [7:0]                param_o,      // Parameter byte
  output logic                      param_valid_o,// Parameter byte pulse
  input  wire logic                 cmd_take_i,   // Executor pops head command
  input  wire logic                 res_valid_i,  // Slave result word valid
  input  wire mscd_pkg::mscd_res_t  res_i,        // Slave result word
  output logic                      res_ready_o,  // Result accepted
  output logic                      bit_tick_o    // Link bit-rate tick
);
  import mscd_pkg::*;

  // Result return states; the unused code 2'b10 falls back to idle
  typedef enum logic [1:0] {
    MSCD_IDLE = 2'b00,
    MSCD_ADDR = 2'b01,
    MSCD_DATA = 2'b11
  } mscd_rst_t;

  ////////////////////////////////////////////////////////////////////////
  // Queue slots hold decoded commands, so the executor never re-decodes;
  // the rest is parameter, result and divider state
  mscd_cmd_t           dec;
  mscd_cmd_t           q [CMD_DEPTH];
  mscd_cmd_t           next_q [CMD_DEPTH];
  logic [1:0]          cnt, next_cnt;
  logic                full, next_full;
  logic [7:0]          param, next_param;
  logic                pvalid, next_pvalid;
  mscd_rst_t           st, next_st;
  logic [7:0]          rbyte, next_rbyte;
  logic [7:0]          rhold, next_rhold;
  logic                obf, next_obf;
  logic [$clog2(BIT_CYCLES)-1:0] div, next_div;
  logic                tick, next_tick;
  logic                push, pop, accept;
  logic                rready, res_take;

  // Opcode decode is purely combinational on the write byte
  mscd_opdec u_dec (
    .opcode_i (wdata_i),
    .cmd_o    (dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command buffer
  // Halt intake while a result waits unread
  // or once the third opcode has set the full flag
  assign accept = !full && !obf;
  assign push   = cmd_wr_i && accept;
  // A pop on an empty queue is ignored so the count cannot wrap
  assign pop    = cmd_take_i && (cnt != 2'h0);

  // Next queue state. A pop and a push in one cycle are legal: the pop
  // shifts first, so the new opcode lands behind the surviving entry.
  // A third opcode is dropped and only raises the full flag.
  always_comb begin
    next_q      = q;
    next_cnt    = cnt;
    next_full   = full;
    next_param  = param;
    next_pvalid = 1'b0;
    if (pop) begin
      next_q[0] = q[1];
      next_cnt  = cnt - 2'h1;
      next_full = 1'b0;
    end
    if (push) begin
      if (next_cnt == 2'(CMD_DEPTH)) begin
        next_full = 1'b1;
      end else begin
        next_q[next_cnt[0]] = dec;
        next_cnt = next_cnt + 2'h1;
      end
    end
    // Parameter bytes pass through the same intake gate as opcodes
    if (data_wr_i && accept) begin
      next_param  = wdata_i;
      next_pvalid = 1'b1;
    end
  end

  // Queue, full flag and parameter registers; reset clears every slot
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int i = 0; i < CMD_DEPTH; i++) begin
        q[i] <= '0;
      end
      cnt    <= 2'h0;
      full   <= 1'b0;
      param  <= 8'h00;
      pvalid <= 1'b0;
    end else begin
      q      <= next_q;
      cnt    <= next_cnt;
      full   <= next_full;
      param  <= next_param;
      pvalid <= next_pvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result return: address byte first, then data byte.
  // A new result is taken only in idle with no byte waiting, so an
  // unread data byte is never overwritten by the next address byte.
  assign rready      = (st == MSCD_IDLE) && !obf;
  assign res_take    = res_valid_i && rready;
  assign res_ready_o = rready;

  // Next result state; a host read clears the waiting flag first
  always_comb begin
    next_st    = st;
    next_rbyte = rbyte;
    next_rhold = rhold;
    next_obf   = obf;
    if (obf && rd_i) begin
      next_obf = 1'b0;
    end
    unique case (st)
      // Latch both bytes, address first for the host
      MSCD_IDLE: begin
        if (res_take) begin
          next_rhold = res_i.data;
          next_rbyte = {4'h0, res_i.addr};
          next_st    = MSCD_ADDR;
        end
      end
      // Present the address byte once the output is empty
      MSCD_ADDR: begin
        if (!obf) begin
          next_obf = 1'b1;
          next_st  = MSCD_DATA;
        end
      end
      // Then the data byte, after the host has read the address
      MSCD_DATA: begin
        if (!obf) begin
          next_rbyte = rhold;
          next_obf   = 1'b1;
          next_st    = MSCD_IDLE;
        end
      end
      default: next_st = MSCD_IDLE;
    endcase
  end

  // Result registers; address and data bytes share one output flop
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st    <= MSCD_IDLE;
      rbyte <= 8'h00;
      rhold <= 8'h00;
      obf   <= 1'b0;
    end else begin
      st    <= next_st;
      rbyte <= next_rbyte;
      rhold <= next_rhold;
      obf   <= next_obf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Link bit-rate divider: counts 0 to BIT_CYCLES-1 and pulses once per
  // wrap. The cycle count is rounded up, so the link never runs faster
  // than its limit.
  always_comb begin
    next_tick = 1'b0;
    next_div  = div + 1'b1;
    if (div == ($clog2(BIT_CYCLES))'(BIT_CYCLES - 1)) begin
      next_div  = '0;
      next_tick = 1'b1;
    end
  end

  // Divider registers; the tick leaves a flip-flop so it is glitch free
  // and lasts exactly one clock
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div  <= '0;
      tick <= 1'b0;
    end else begin
      div  <= next_div;
      tick <= next_tick;
    end
  end


  ////////////////////////////////////////////////////////////////////////
  // Outputs. The interrupt follows the waiting flag, so it stays up
  // until the host has read the byte that raised it.
  // Handshake ready is combinational; data outputs come from flip-flops.
  assign input_buffer_full_flag_o = full;
  assign rdata_o       = rbyte;
  assign obf_o         = obf;
  assign irq_o         = obf;
  assign cmd_valid_o   = (cnt != 2'h0);
  assign cmd_o         = q[0];
  assign param_o       = param;
  assign param_valid_o = pvalid;
  assign bit_tick_o    = tick;
endmodule // mscd_top
`default_nettype wire

//--- mscd_top_checker.sv
// Port checker of the command decoder top
`timescale 1ns/10ps
`default_nettype none
module mscd_top_checker
  import mscd_pkg::*;
(
  input wire logic        clock_i,     // Clock
  input wire logic        resetn_i,    // Reset
  input wire logic        cmd_wr_i,    // Cmd write
  input wire logic        data_wr_i,   // Data write
  input wire logic [7:0]  wdata_i,     // Write byte
  input wire logic        rd_i,        // Host read
  input wire logic        input_buffer_full_flag_o, // Full
  input wire logic [7:0]  rdata_o,     // Result byte
  input wire logic        obf_o,       // Byte waiting
  input wire logic        irq_o,       // Interrupt
  input wire logic        cmd_valid_o, // Head valid
  input wire mscd_cmd_t   cmd_o,       // Head
  input wire logic [7:0]  param_o,     // Param
  input wire logic        param_valid_o, // Param pulse
  input wire logic        cmd_take_i,  // Pop
  input wire logic        res_valid_i, // Result valid
  input wire mscd_res_t   res_i,       // Result
  input wire logic        res_ready_o, // Result ready
  input wire logic        bit_tick_o   // Link tick
);
  logic        acc;
  logic [10:0] gap;
  logic        seen;
  logic [10:0] next_gap;
  logic        next_seen;
  assign acc = !input_buffer_full_flag_o && !obf_o;
  // Cycles since the last link tick
  always_comb begin
    next_gap = bit_tick_o ? 11'h000 : gap + 11'h001;
    next_seen = seen | bit_tick_o;
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap <= 11'h000;
      seen <= 1'b0;
    end else begin
      gap <= next_gap;
      seen <= next_seen;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  //////////////////////////////////////////////////////////////////////////////
  irq_level_a : assert property (
    irq_o == obf_o) else $error("irq differs from obf");
  rdata_hold_a : assert property (
    obf_o && !rd_i |=> obf_o && $stable(rdata_o)) else $error("waiting byte changed early");
  full_cause_a : assert property (
    $rose(input_buffer_full_flag_o) |-> $past(cmd_wr_i) && $past(cmd_valid_o))
    else $error("full set without a third opcode");
  full_hold_a : assert property (
    input_buffer_full_flag_o && !cmd_take_i |=> input_buffer_full_flag_o)
    else $error("full dropped without a pop");
  decode_a : assert property (
    cmd_wr_i && acc && !cmd_valid_o |=> cmd_valid_o && cmd_o.cls == $past(wdata_i[5:4])
      && cmd_o.code == $past(wdata_i[3:0])) else $error("opcode decode wrong");
  slave_known_a : assert property (
    cmd_valid_o && cmd_o.cls != MSCD_SYSTEM |-> cmd_o.known)
    else $error("slave command not known");
  param_pass_a : assert property (
    data_wr_i && acc |=> param_valid_o && param_o == $past(wdata_i))
    else $error("parameter byte lost");
  param_refuse_a : assert property (
    data_wr_i && !acc |=> !param_valid_o) else $error("refused byte passed");
  addr_first_a : assert property (
    res_valid_i && res_ready_o && !obf_o |-> ##2 obf_o
      && rdata_o == {4'h0, $past(res_i.addr, 2)}) else $error("address byte not first");
  tick_gap_a : assert property (
    seen |-> (bit_tick_o ? gap == 11'h63F : gap < 11'h63F)) else $error("tick spacing wrong");
endmodule // mscd_top_checker
bind mscd_top mscd_top_checker i_chk (.clock_i(clock_i), .resetn_i(resetn_i),
  .cmd_wr_i(cmd_wr_i), .data_wr_i(data_wr_i), .wdata_i(wdata_i), .rd_i(rd_i),
  .input_buffer_full_flag_o(input_buffer_full_flag_o), .rdata_o(rdata_o), .obf_o(obf_o),
  .irq_o(irq_o), .cmd_valid_o(cmd_valid_o), .cmd_o(cmd_o), .param_o(param_o),
  .param_valid_o(param_valid_o), .cmd_take_i(cmd_take_i), .res_valid_i(res_valid_i),
  .res_i(res_i), .res_ready_o(res_ready_o), .bit_tick_o(bit_tick_o));
`default_nettype wire

//--- mscd_host_model.sv
// Host model: writes opcode and data bytes, reads result bytes
`timescale 1ns/10ps
`default_nettype none
module mscd_host_model (
  input  wire logic       clock_i,   // Clock
  input  wire logic       full_i,    // Full flag
  output logic            cmd_wr_o,  // Cmd write
  output logic            data_wr_o, // Data write
  output logic [7:0]      wdata_o,   // Write byte
  output logic            rd_o       // Read
);
  // Idle bus at start
  initial begin
    cmd_wr_o = 1'b0;
    data_wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  // One byte; waits for the full flag to clear unless told to push
  task automatic wr(input logic c, input logic [7:0] b, input logic push);
    for (int n = 0; n < 100 && full_i && !push; n++) begin
      @(posedge clock_i);
      #1;
    end
    cmd_wr_o = c;
    data_wr_o = !c;
    wdata_o = b;
    @(posedge clock_i);
    #1;
  endtask
  // Release strobes; released bus shows the inverse byte
  task automatic rel();
    cmd_wr_o = 1'b0;
    data_wr_o = 1'b0;
    wdata_o = ~wdata_o;
    @(posedge clock_i);
    #1;
  endtask
  // Read strobe pulse
  task automatic rd();
    rd_o = 1'b1;
    @(posedge clock_i);
    #1;
    rd_o = 1'b0;
  endtask
endmodule // mscd_host_model
`default_nettype wire

//--- test_motion_slave_command_decoder.sv
// Self-checking testbench of the command decoder
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", n, e, a); end end
module test_motion_slave_command_decoder;
  import mscd_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       cmd_wr, data_wr, rd, full, obf, irq, cmd_valid, param_valid;
  logic       cmd_take = 1'b0, res_valid = 1'b0, res_ready, tick;
  logic [7:0] wdata, rdata, param;
  mscd_cmd_t  cmd;
  mscd_res_t  res = '0;
  int         n_mismatch = 0;
  int         tests_run = 0;
  always #2.5 clock_i = ~clock_i;
  mscd_host_model i_host (.clock_i(clock_i), .full_i(full), .cmd_wr_o(cmd_wr),
    .data_wr_o(data_wr), .wdata_o(wdata), .rd_o(rd));
  mscd_top i_dut (.clock_i(clock_i), .resetn_i(resetn_i), .cmd_wr_i(cmd_wr),
    .data_wr_i(data_wr), .wdata_i(wdata), .rd_i(rd), .input_buffer_full_flag_o(full),
    .rdata_o(rdata), .obf_o(obf), .irq_o(irq), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .param_o(param), .param_valid_o(param_valid), .cmd_take_i(cmd_take),
    .res_valid_i(res_valid), .res_i(res), .res_ready_o(res_ready), .bit_tick_o(tick));
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic pop();
    cmd_take = 1'b1;
    @(posedge clock_i);
    #1;
    cmd_take = 1'b0;
  endtask
  // Every class, address and selector, with bits 7:6 varied
  task automatic t_decode();
    logic [7:0] op;
    for (int i = 0; i < 64; i++) begin
      op = {i[1:0], i[5:0]};
      i_host.wr(1'b1, op, 1'b0);
      `CHK("cls", op[5:4], cmd.cls)
      `CHK("code", op[3:0], cmd.code)
      `CHK("known", op[5:4] != 2'h3 || op[3:0] <= 4'h9 || op[3:0] == 4'hF, cmd.known)
      i_host.rel();
      pop();
    end
  endtask
  // Third opcode sets full, later bytes refused, pop clears
  task automatic t_full();
    i_host.wr(1'b1, 8'h31, 1'b0);
    i_host.wr(1'b1, 8'h12, 1'b0);
    i_host.wr(1'b1, 8'h25, 1'b0);
    i_host.wr(1'b0, 8'h5A, 1'b1);
    `CHK("full", 1'b1, full)
    `CHK("pv", 1'b0, param_valid)
    `CHK("head", 4'h1, cmd.code)
    i_host.rel();
    pop();
    `CHK("full", 1'b0, full)
    `CHK("next", 4'h2, cmd.code)
    pop();
    i_host.wr(1'b1, 8'h38, 1'b0);
    i_host.wr(1'b0, 8'hA7, 1'b0);
    `CHK("param", 8'hA7, param)
    `CHK("pv", 1'b1, param_valid)
    i_host.rel();
    pop();
    pop();
  endtask
  task automatic get(input logic [7:0] e);
    for (int n = 0; n < 50 && obf !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    `CHK("obf", 1'b1, obf)
    `CHK("rdata", e, rdata)
    `CHK("irq", 1'b1, irq)
    i_host.rd();
  endtask
  task automatic send(input logic [3:0] a, input logic [7:0] d);
    res_valid = 1'b1;
    res = '{addr: a, data: d};
    for (int n = 0; n < 50 && res_ready !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    `CHK("res_ready", 1'b1, res_ready)
    @(posedge clock_i);
    #1;
    res_valid = 1'b0;
    res = '{addr: ~a, data: ~d};
  endtask
  // Results return out of issue order, each led by its address
  task automatic t_result();
    i_host.wr(1'b1, 8'h22, 1'b0);
    i_host.wr(1'b1, 8'h25, 1'b0);
    i_host.rel();
    pop();
    pop();
    send(4'h5, 8'hA5);
    get(8'h05);
    @(posedge clock_i);
    #1;
    `CHK("obf", 1'b1, obf)
    i_host.wr(1'b1, 8'h31, 1'b1);
    i_host.rel();
    `CHK("cvalid", 1'b0, cmd_valid)
    get(8'hA5);
    send(4'h2, 8'h3C);
    get(8'h02);
    get(8'h3C);
  endtask
  // Link tick every 1600 clocks
  task automatic t_tick();
    int n;
    for (n = 0; n < 2000 && tick !== 1'b1; n++) begin
      @(posedge clock_i);
      #1;
    end
    for (n = 1; n < 2000; n++) begin
      @(posedge clock_i);
      #1;
      if (tick === 1'b1) break;
    end
    `CHK("gap", 1600, n)
  endtask
  initial begin
    repeat (5) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    t_decode();
    t_full();
    t_result();
    t_tick();
    stop_test();
  end
  // Watchdog
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule // test_motion_slave_command_decoder
`default_nettype wire
